// >>> rtl/can_controller_mode_status.sv
`timescale 1ns/1ps
module can_controller_mode_status #(
	parameter int unsigned NUM_FILTERS = 16,
	parameter int unsigned NUM_MASKS = 4,
	parameter int unsigned NUM_PROG_BUFFERS = 6,
	parameter int unsigned NUM_TX_BUFFERS = 3,
	parameter int unsigned NUM_RX_BUFFERS = 2,
	parameter int unsigned WAKE_CYCLES = can_ctrl_pkg::WAKE_FILTER_CYCLES
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic bus_idle_i,
	input wire logic [2:0] tx_pending_i,
	input wire logic [3:0] fifo_read_pointer_i,
	input wire can_ctrl_pkg::irq_src_t irq_src_i,
	input wire can_ctrl_pkg::frame_info_t frame_i,
	input wire logic engine_tx_i,
	input wire logic bus_receive_pin_i,
	input wire logic tx_pin_direction_a_i,
	input wire logic tx_pin_direction_b_i,
	output logic [2:0] current_op_mode_o,
	output logic [1:0] buffer_mode_o,
	output logic abort_all_tx_o,
	output logic [2:0] buffer_window_select_o,
	output logic [7:0] bit_cycles_o,
	output logic engine_rx_o,
	output logic bus_transmit_pin_a_o,
	output logic bus_transmit_pin_a_oe_n_o,
	output logic bus_transmit_pin_b_o,
	output logic bus_transmit_pin_b_oe_n_o,
	output logic frame_store_o,
	output logic [3:0] payload_len_o,
	output logic wake_event_o
);
	localparam int WCW = $clog2(WAKE_CYCLES + 1);
	localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES - 1);
	localparam logic [WCW-1:0] WAKE_FULL = WCW'(WAKE_CYCLES);
	localparam logic [7:0] MIN_BIT = 8'(can_ctrl_pkg::MIN_BIT_CYCLES);

	// bus handshake: one wait cycle, then one cycle with waitrequest low
	logic ack_r;
	logic ack_nxt;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	wire logic req = avs_read_i | avs_write_i;
	wire logic wr_take = avs_write_i & ack_r & avs_byteenable_i[0];
	wire logic [7:0] wbyte = avs_writedata_i[7:0];
	wire logic sel_ctrl = avs_address_i[4:2] == can_ctrl_pkg::OFS_CONTROL[4:2];
	wire logic sel_stat = avs_address_i[4:2] == can_ctrl_pkg::OFS_STATUS[4:2];
	wire logic sel_bmode = avs_address_i[4:2] == can_ctrl_pkg::OFS_BUF_MODE[4:2];
	wire logic sel_bit = avs_address_i[4:2] == can_ctrl_pkg::OFS_BIT_TIME[4:2];
	wire logic sel_wake = avs_address_i[4:2] == can_ctrl_pkg::OFS_WAKE_CFG[4:2];
	wire logic sel_caps = avs_address_i[4:2] == can_ctrl_pkg::OFS_CAPS[4:2];

	assign ack_nxt = req & ~ack_r;

	// control state
	logic [2:0] req_mode_r;
	logic [2:0] op_mode_r;
	logic [2:0] op_mode_nxt;
	logic abort_r;
	logic abort_nxt;
	logic [2:0] win_r;
	logic [1:0] bmode_pend_r;
	logic [1:0] bmode_act_r;
	logic [7:0] bit_cycles_r;
	logic wake_en_r;

	wire logic in_cfg = op_mode_r == can_ctrl_pkg::MODE_CONFIG;
	wire logic want_cfg = req_mode_r[2];
	wire logic legacy = bmode_act_r == can_ctrl_pkg::BMODE_LEGACY;
	wire logic fifo = bmode_act_r == can_ctrl_pkg::BMODE_FIFO;

	// configuration entry waits for an idle bus so a frame in flight is not cut
	assign op_mode_nxt = want_cfg ? (bus_idle_i ? can_ctrl_pkg::MODE_CONFIG : op_mode_r)
		: req_mode_r;
	wire logic leave_cfg = in_cfg & (op_mode_nxt != can_ctrl_pkg::MODE_CONFIG);

	wire logic wr_ctrl = wr_take & sel_ctrl;
	wire logic abort_set = wr_ctrl & wbyte[can_ctrl_pkg::ABORT_BIT];
	// set wins over the self-clear so a late write is never lost
	assign abort_nxt = abort_set | (abort_r & (tx_pending_i != 3'h0));

	wire logic [1:0] bmode_wr = wbyte[can_ctrl_pkg::BMODE_MSB:can_ctrl_pkg::BMODE_LSB];
	wire logic bmode_ok = wr_take & sel_bmode & in_cfg
		& (bmode_wr != can_ctrl_pkg::BMODE_RSVD);

	wire logic [7:0] bit_wr = (wbyte < MIN_BIT) ? MIN_BIT : wbyte;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_mode_r <= can_ctrl_pkg::REQ_RESET;
			op_mode_r <= can_ctrl_pkg::MODE_CONFIG;
			abort_r <= 1'b0;
			win_r <= can_ctrl_pkg::CODE_NONE;
		end else begin
			if (wr_ctrl) begin
				req_mode_r <= wbyte[can_ctrl_pkg::REQ_MODE_MSB:can_ctrl_pkg::REQ_MODE_LSB];
			end
			op_mode_r <= op_mode_nxt;
			abort_r <= abort_nxt;
			if (wr_ctrl && legacy) begin
				win_r <= wbyte[can_ctrl_pkg::WIN_MSB:can_ctrl_pkg::WIN_LSB];
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bmode_pend_r <= can_ctrl_pkg::BMODE_LEGACY;
			bmode_act_r <= can_ctrl_pkg::BMODE_LEGACY;
			bit_cycles_r <= MIN_BIT;
			wake_en_r <= can_ctrl_pkg::WAKE_CFG_RESET[0];
		end else begin
			if (bmode_ok) begin
				bmode_pend_r <= bmode_wr;
			end
			if (leave_cfg) begin
				bmode_act_r <= bmode_pend_r;
			end
			if (wr_take && sel_bit && in_cfg) begin
				bit_cycles_r <= bit_wr;
			end
			if (wr_take && sel_wake) begin
				wake_en_r <= wbyte[0];
			end
		end
	end

	// legacy interrupt priority: error, receive, transmit, then wake-up
	wire logic [2:0] icode = irq_src_i.err ? can_ctrl_pkg::CODE_ERR
		: irq_src_i.rx0 ? can_ctrl_pkg::CODE_RX0
		: irq_src_i.rx1 ? can_ctrl_pkg::CODE_RX1
		: irq_src_i.tx0 ? can_ctrl_pkg::CODE_TX0
		: irq_src_i.tx1 ? can_ctrl_pkg::CODE_TX1
		: irq_src_i.tx2 ? can_ctrl_pkg::CODE_TX2
		: irq_src_i.wake ? can_ctrl_pkg::CODE_WAKE
		: can_ctrl_pkg::CODE_NONE;

	// lowest-numbered programmable buffer wins
	logic [4:0] prog_code [NUM_PROG_BUFFERS+1];
	logic prog_hit [NUM_PROG_BUFFERS+1];
	assign prog_code[NUM_PROG_BUFFERS] = can_ctrl_pkg::ECODE_NONE;
	assign prog_hit[NUM_PROG_BUFFERS] = 1'b0;
	genvar g;
	generate
		for (g = NUM_PROG_BUFFERS - 1; g >= 0; g--) begin : g_prog
			wire logic rx_fifo = fifo & irq_src_i.prog_is_rx[g];
			assign prog_hit[g] = irq_src_i.prog[g] | prog_hit[g+1];
			assign prog_code[g] = !irq_src_i.prog[g] ? prog_code[g+1]
				: rx_fifo ? can_ctrl_pkg::ECODE_RX0
				: can_ctrl_pkg::ECODE_PROG0 + 5'(g);
		end
	endgenerate

	wire logic [4:0] ecode = irq_src_i.err ? can_ctrl_pkg::ECODE_ERR
		: irq_src_i.rx0 ? can_ctrl_pkg::ECODE_RX0
		: irq_src_i.rx1 ? (fifo ? can_ctrl_pkg::ECODE_RX0 : can_ctrl_pkg::ECODE_RX1)
		: prog_hit[0] ? prog_code[0]
		: irq_src_i.tx0 ? can_ctrl_pkg::ECODE_TX0
		: irq_src_i.tx1 ? can_ctrl_pkg::ECODE_TX1
		: irq_src_i.tx2 ? can_ctrl_pkg::ECODE_TX2
		: irq_src_i.wake ? can_ctrl_pkg::ECODE_WAKE
		: can_ctrl_pkg::ECODE_NONE;

	// status mirrors the settled mode only, never the request
	wire logic [7:0] status_val = legacy ? {op_mode_r, 1'b0, icode, 1'b0}
		: {op_mode_r, ecode};
	wire logic [3:0] ctrl_low = legacy ? {win_r, 1'b0}
		: fifo ? fifo_read_pointer_i
		: 4'h0;
	wire logic [7:0] ctrl_val = {req_mode_r, abort_r, ctrl_low};
	wire logic [7:0] bmode_val = {bmode_pend_r, 4'h0, bmode_act_r};
	wire logic [7:0] caps_val = {3'(NUM_MASKS - 1), 5'(NUM_FILTERS - 1)};
	wire logic [7:0] caps_hi = {1'b1, 1'b1, 2'(NUM_RX_BUFFERS),
		2'(NUM_TX_BUFFERS), 2'h0};
	wire logic [7:0] caps_top = 8'(NUM_PROG_BUFFERS);

	assign rdata_nxt = !(avs_read_i && ack_nxt) ? 32'h0
		: sel_ctrl ? {24'h0, ctrl_val}
		: sel_stat ? {24'h0, status_val}
		: sel_bmode ? {24'h0, bmode_val}
		: sel_bit ? {24'h0, bit_cycles_r}
		: sel_wake ? {31'h0, wake_en_r}
		: sel_caps ? {8'h0, caps_top, caps_hi, caps_val}
		: 32'h0;

	// waitrequest kept in its own flop so the bus never sees an inverter output
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_r <= 1'b0;
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			ack_r <= ack_nxt;
			wait_r <= ~ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest_o = wait_r;
	assign avs_readdata_o = rdata_r;

	// pin side
	wire logic normal = op_mode_r == can_ctrl_pkg::MODE_NORMAL;
	wire logic loop = op_mode_r == can_ctrl_pkg::MODE_LOOPBACK;
	// only normal mode may disturb the bus; other modes send recessive
	wire logic tx_bit = normal ? engine_tx_i : 1'b1;
	wire logic oe_a_n = normal ? 1'b0 : tx_pin_direction_a_i;
	wire logic oe_b_n = normal ? 1'b0 : tx_pin_direction_b_i;
	wire logic rx_bit = loop ? engine_tx_i : bus_receive_pin_i;

	wire logic stored = frame_i.done & ~frame_i.error & frame_i.filter_hit;
	wire logic [3:0] plen = (frame_i.dlc > can_ctrl_pkg::MAX_PAYLOAD)
		? can_ctrl_pkg::MAX_PAYLOAD : frame_i.dlc;

	// wake filter: dominant level must persist, glitches restart the count
	logic [WCW-1:0] wake_cnt_r;
	wire logic wake_arm = wake_en_r & (op_mode_r == can_ctrl_pkg::MODE_DISABLE);
	wire logic dominant = ~bus_receive_pin_i;
	wire logic wake_hit = wake_arm & dominant & (wake_cnt_r == WAKE_LAST);
	wire logic [WCW-1:0] wake_cnt_nxt = !(wake_arm && dominant) ? '0
		: (wake_cnt_r == WAKE_FULL) ? wake_cnt_r : wake_cnt_r + WCW'(1);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_cnt_r <= '0;
			wake_event_o <= 1'b0;
			bus_transmit_pin_a_o <= 1'b1;
			bus_transmit_pin_b_o <= 1'b1;
			bus_transmit_pin_a_oe_n_o <= 1'b1;
			bus_transmit_pin_b_oe_n_o <= 1'b1;
			engine_rx_o <= 1'b1;
			frame_store_o <= 1'b0;
			payload_len_o <= 4'h0;
		end else begin
			wake_cnt_r <= wake_cnt_nxt;
			wake_event_o <= wake_hit;
			bus_transmit_pin_a_o <= tx_bit;
			bus_transmit_pin_b_o <= tx_bit;
			bus_transmit_pin_a_oe_n_o <= oe_a_n;
			bus_transmit_pin_b_oe_n_o <= oe_b_n;
			engine_rx_o <= rx_bit;
			frame_store_o <= stored;
			payload_len_o <= plen;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			current_op_mode_o <= can_ctrl_pkg::MODE_CONFIG;
			buffer_mode_o <= can_ctrl_pkg::BMODE_LEGACY;
			abort_all_tx_o <= 1'b0;
			buffer_window_select_o <= can_ctrl_pkg::CODE_RX0;
			bit_cycles_o <= MIN_BIT;
		end else begin
			current_op_mode_o <= op_mode_nxt;
			buffer_mode_o <= leave_cfg ? bmode_pend_r : bmode_act_r;
			abort_all_tx_o <= abort_nxt;
			buffer_window_select_o <= win_map(win_r);
			bit_cycles_o <= bit_cycles_r;
		end
	end

	// unused window codes fall back to receive buffer 0
	function automatic logic [2:0] win_map(input logic [2:0] w);
		case (w)
			can_ctrl_pkg::CODE_RX1: win_map = can_ctrl_pkg::CODE_RX1;
			can_ctrl_pkg::CODE_TX0: win_map = can_ctrl_pkg::CODE_TX0;
			can_ctrl_pkg::CODE_TX1: win_map = can_ctrl_pkg::CODE_TX1;
			can_ctrl_pkg::CODE_TX2: win_map = can_ctrl_pkg::CODE_TX2;
			default: win_map = can_ctrl_pkg::CODE_RX0;
		endcase
	endfunction
endmodule

// >>> rtl/can_ctrl_pkg.sv
// Function
// - send and receive standard and extended data frames with 0 to 8 bytes
// - bit rate programmable, fastest rate one megabit per second
// - sixteen full acceptance filters, each linkable to one of four masks
// - six message buffers, each configurable as receive or transmit
// - three transmit buffers with software priority and abort of pending sends
// - double-buffered receiver with two prioritized receive buffers
// - frames are checked for errors first, then matched against filters
// - remote, error, overload frames and interframe space handled in hardware
// - in normal mode the controller owns direction of both transmit pins
// - requested mode bits 7:5: 1xx config, 011 listen, 010 loopback, 001 disable, 000 normal
// - abort bit 4 cancels all pending transmissions in every transmit buffer
// - legacy window bits 3:1 pick the buffer mapped into the access window
// - fifo mode: bits 3:0 read-only next-buffer pointer; enhanced legacy reads zero
// - status bits 7:5 report the current operating mode
// - legacy status bits 3:1 hold the highest-priority pending interrupt source
// - legacy interrupt code uses the same encoding as the window field
// - modes 1 and 2: status bits 4:0 hold a five-bit prioritized source code
// - fifo mode: any interrupt from a receive-configured buffer reports 10000
// - programmable wake-up on bus activity through a low-pass filter
// - loopback mode routes transmitted bits internally back to the receiver
// - configuration request waits for bus idle; other modes take effect at once
// - buffer mode: 00 legacy, 01 enhanced legacy, 10 fifo, 11 reserved
// - buffer mode writable only in configuration, effective after leaving it
package can_ctrl_pkg;
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_BUF_MODE = 5'h08;
	localparam logic [4:0] OFS_BIT_TIME = 5'h0c;
	localparam logic [4:0] OFS_WAKE_CFG = 5'h10;
	localparam logic [4:0] OFS_CAPS = 5'h14;

	localparam int REQ_MODE_MSB = 7;
	localparam int REQ_MODE_LSB = 5;
	localparam int ABORT_BIT = 4;
	localparam int WIN_MSB = 3;
	localparam int WIN_LSB = 1;
	localparam int BMODE_MSB = 7;
	localparam int BMODE_LSB = 6;

	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_DISABLE = 3'h1;
	localparam logic [2:0] MODE_LOOPBACK = 3'h2;
	localparam logic [2:0] MODE_LISTEN = 3'h3;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] REQ_RESET = 3'h4;

	localparam logic [1:0] BMODE_LEGACY = 2'h0;
	localparam logic [1:0] BMODE_ENH = 2'h1;
	localparam logic [1:0] BMODE_FIFO = 2'h2;
	localparam logic [1:0] BMODE_RSVD = 2'h3;

	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_ERR = 3'h1;
	localparam logic [2:0] CODE_TX2 = 3'h2;
	localparam logic [2:0] CODE_TX1 = 3'h3;
	localparam logic [2:0] CODE_TX0 = 3'h4;
	localparam logic [2:0] CODE_RX1 = 3'h5;
	localparam logic [2:0] CODE_RX0 = 3'h6;
	localparam logic [2:0] CODE_WAKE = 3'h7;

	localparam logic [4:0] ECODE_NONE = 5'h00;
	localparam logic [4:0] ECODE_ERR = 5'h02;
	localparam logic [4:0] ECODE_TX2 = 5'h04;
	localparam logic [4:0] ECODE_TX1 = 5'h06;
	localparam logic [4:0] ECODE_TX0 = 5'h08;
	localparam logic [4:0] ECODE_WAKE = 5'h0e;
	localparam logic [4:0] ECODE_RX0 = 5'h10;
	localparam logic [4:0] ECODE_RX1 = 5'h11;
	localparam logic [4:0] ECODE_PROG0 = 5'h12;

	localparam int CLOCK_HZ = 25000000;
	localparam int BIT_TIME_MIN_NS = 1000;
	localparam int MIN_BIT_CYCLES = (BIT_TIME_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int WAKE_FILTER_NS = 2000;
	localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam logic [3:0] MAX_PAYLOAD = 4'h8;
	localparam logic [7:0] WAKE_CFG_RESET = 8'h00;

	typedef struct packed {
		logic wake;
		logic err;
		logic tx2;
		logic tx1;
		logic tx0;
		logic rx1;
		logic rx0;
		logic [5:0] prog;
		logic [5:0] prog_is_rx;
	} irq_src_t;

	typedef struct packed {
		logic done;
		logic error;
		logic filter_hit;
		logic [3:0] dlc;
	} frame_info_t;
endpackage

// >>> verif/can_bus_node_model.sv
`timescale 1ns/1ps
module can_bus_node_model (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic busy_i,
	input wire logic [2:0] load_i,
	input wire logic abort_i,
	input wire logic tx_pin_i,
	output logic bus_idle_o,
	output logic [2:0] tx_pending_o,
	output logic rx_pin_o
);
	logic [1:0] slow_r;
	logic traffic_r;
	// wired-and bus: other nodes show traffic while busy, idle rests recessive
	assign rx_pin_o = tx_pin_i & (~busy_i | traffic_r);
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slow_r <= 2'h0;
			traffic_r <= 1'b1;
			bus_idle_o <= 1'b1;
			tx_pending_o <= 3'h0;
		end else begin
			slow_r <= slow_r + 2'h1;
			// four clocks dominant, four recessive: long enough to pass the wake filter
			if (slow_r == 2'h3)
				traffic_r <= ~traffic_r;
			bus_idle_o <= ~busy_i;
			// slow cancel, one buffer per four clocks, so a waiting abort is visible
			if (load_i != 3'h0)
				tx_pending_o <= load_i;
			else if (abort_i && slow_r == 2'h0)
				tx_pending_o <= tx_pending_o & (tx_pending_o - 3'h1);
		end
	end
endmodule

// >>> verif/can_mode_status_properties.sv
`timescale 1ns/1ps
module can_mode_status_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic bus_idle_i,
	input wire logic [2:0] tx_pending_i,
	input wire can_ctrl_pkg::frame_info_t frame_i,
	input wire logic engine_tx_i,
	input wire logic tx_pin_direction_a_i,
	input wire logic [2:0] current_op_mode_o,
	input wire logic [1:0] buffer_mode_o,
	input wire logic abort_all_tx_o,
	input wire logic [2:0] buffer_window_select_o,
	input wire logic engine_rx_o,
	input wire logic bus_transmit_pin_a_oe_n_o,
	input wire logic bus_transmit_pin_b_oe_n_o,
	input wire logic frame_store_o,
	input wire logic [3:0] payload_len_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	wire ctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i[4:2] == 3'h0
		&& avs_byteenable_i[0];
	wire [2:0] wd_win = avs_writedata_i[3:1];
	// unused window codes all land on the first receive buffer
	wire [2:0] win_map = (wd_win inside {[3'h2:3'h5]}) ? wd_win : 3'h6;

	abort_set_a: assert property (ctl_wr && avs_writedata_i[4] |=> abort_all_tx_o)
		else $error("abort request not raised");
	abort_hold_a: assert property (abort_all_tx_o && tx_pending_i != 3'h0 |=> abort_all_tx_o)
		else $error("abort dropped while sends pending");
	pin_own_a: assert property ($past(nrst_i) |-> bus_transmit_pin_a_oe_n_o ==
		($past(current_op_mode_o) != can_ctrl_pkg::MODE_NORMAL && $past(tx_pin_direction_a_i))
		&& ($past(current_op_mode_o) != can_ctrl_pkg::MODE_NORMAL || !bus_transmit_pin_b_oe_n_o))
		else $error("transmit pin direction wrong");
	loop_rx_a: assert property ($past(nrst_i)
		&& $past(current_op_mode_o) == can_ctrl_pkg::MODE_LOOPBACK |-> engine_rx_o == $past(engine_tx_i))
		else $error("loopback receive path wrong");
	mode_apply_a: assert property (ctl_wr && !avs_writedata_i[7]
		|-> ##2 current_op_mode_o == $past(avs_writedata_i[7:5], 2))
		else $error("requested mode not applied");
	cfg_idle_a: assert property ($changed(current_op_mode_o)
		&& current_op_mode_o == can_ctrl_pkg::MODE_CONFIG |-> $past(bus_idle_i))
		else $error("configuration entered on busy bus");
	frame_store_a: assert property ($past(nrst_i) |-> frame_store_o ==
		$past(frame_i.done && !frame_i.error && frame_i.filter_hit))
		else $error("frame store pulse wrong");
	win_map_a: assert property (ctl_wr && buffer_mode_o == can_ctrl_pkg::BMODE_LEGACY
		|-> ##2 buffer_window_select_o == $past(win_map, 2))
		else $error("window select wrong");
	plen_a: assert property ($past(nrst_i) |-> payload_len_o ==
		($past(frame_i.dlc) > 4'h8 ? 4'h8 : $past(frame_i.dlc)))
		else $error("payload length wrong");
endmodule

bind can_controller_mode_status can_mode_status_checker u_chk (.clock_i, .nrst_i, .avs_address_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .bus_idle_i,
	.tx_pending_i, .frame_i, .engine_tx_i, .tx_pin_direction_a_i, .current_op_mode_o,
	.buffer_mode_o, .abort_all_tx_o, .buffer_window_select_o, .engine_rx_o,
	.bus_transmit_pin_a_oe_n_o, .bus_transmit_pin_b_oe_n_o, .frame_store_o, .payload_len_o);

// >>> verif/test_can_controller_mode_status.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_can_controller_mode_status;
	localparam logic [4:0] CTL = can_ctrl_pkg::OFS_CONTROL;
	localparam logic [4:0] STA = can_ctrl_pkg::OFS_STATUS;
	localparam logic [4:0] BMD = can_ctrl_pkg::OFS_BUF_MODE;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0, wr = 1'b0, wait_o, idle, abort, tx_a, rx_pin, busy = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [2:0] pend, load = 3'h0, code, win;
	logic [3:0] fifo_ptr = 4'h0;
	logic [2:0] wsel;
	logic [7:0] bitc;
	logic wake;
	int wakes = 0;
	can_ctrl_pkg::irq_src_t irq = '0;
	can_ctrl_pkg::frame_info_t frame = '0;
	logic eng_tx = 1'b1, dir_a = 1'b1, dir_b = 1'b1;
	logic [18:0] ein[4] = '{19'h2000, 19'h4000, 19'h0040, 19'h0041};
	logic [4:0] eout[4] = '{5'h10, 5'h08, 5'h12, 5'h10};
	integer seed = 32'h926a;
	int miscompares = 0, n_checks = 0;

	always #20 clock_i = ~clock_i;

	can_controller_mode_status #(.WAKE_CYCLES(3)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.bus_idle_i(idle), .tx_pending_i(pend), .fifo_read_pointer_i(fifo_ptr), .irq_src_i(irq),
		.frame_i(frame), .engine_tx_i(eng_tx), .bus_receive_pin_i(rx_pin),
		.tx_pin_direction_a_i(dir_a), .tx_pin_direction_b_i(dir_b), .current_op_mode_o(),
		.buffer_mode_o(), .abort_all_tx_o(abort), .buffer_window_select_o(wsel),
		.bit_cycles_o(bitc),
		.engine_rx_o(), .bus_transmit_pin_a_o(tx_a), .bus_transmit_pin_a_oe_n_o(),
		.bus_transmit_pin_b_o(), .bus_transmit_pin_b_oe_n_o(), .frame_store_o(),
		.payload_len_o(), .wake_event_o(wake));

	can_bus_node_model u_node (.clock_i(clock_i), .nrst_i(nrst_i), .busy_i(busy), .load_i(load),
		.abort_i(abort), .tx_pin_i(tx_a), .bus_idle_o(idle), .tx_pending_o(pend),
		.rx_pin_o(rx_pin));

	function automatic logic [2:0] icode(can_ctrl_pkg::irq_src_t s);
		return s.err ? 3'h1 : s.rx0 ? 3'h6 : s.rx1 ? 3'h5 : s.tx0 ? 3'h4 : s.tx1 ? 3'h3
			: s.tx2 ? 3'h2 : s.wake ? 3'h7 : 3'h0;
	endfunction

	function automatic logic [2:0] wmap(logic [2:0] w);
		return (w inside {[3'h2:3'h5]}) ? w : 3'h6;
	endfunction

	// holds the request until the edge that sees waitrequest low, then releases
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock_i);
		adr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clock_i);
		end while (wait_o !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clock_i) begin
		if (wake === 1'b1)
			wakes++;
	end

	always @(posedge clock_i) begin
		eng_tx <= 1'($random(seed));
		frame <= 7'($random(seed));
		dir_a <= 1'($random(seed));
		dir_b <= 1'($random(seed));
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		bus(1'b0, CTL, 8'h00);
		`CHK(q[7:0], 8'h80)
		bus(1'b0, STA, 8'h00);
		`CHK(q[7:0], 8'h80)
		bus(1'b0, 5'h18, 8'h00);
		`CHK(q, 32'h0)
		$display("test reset done");
		load <= 3'h7;
		@(posedge clock_i);
		load <= 3'h0;
		bus(1'b1, CTL, 8'h9c);
		bus(1'b0, CTL, 8'h00);
		`CHK(q[4], 1'b1)
		repeat (20) @(posedge clock_i);
		bus(1'b0, CTL, 8'h00);
		`CHK(q[4], 1'b0)
		$display("test abort done");
		for (int i = 0; i < 12; i++) begin
			irq <= (i < 7) ? (19'h1000 << i) : 19'($random(seed));
			bus(1'b0, STA, 8'h00);
			code = icode(irq);
			`CHK(q[7:0], {4'h8, code, 1'b0})
			win = (i < 7) ? code : 3'($random(seed));
			bus(1'b1, CTL, {4'h8, win, 1'b0});
			bus(1'b0, CTL, 8'h00);
			`CHK(q[7:0], {4'h8, win, 1'b0})
			`CHK(wsel, wmap(win))
		end
		irq <= '0;
		$display("test interrupt code done");
		bus(1'b1, BMD, 8'hc0);
		bus(1'b0, BMD, 8'h00);
		`CHK(q[7:0], 8'h00)
		bus(1'b1, BMD, 8'h80);
		bus(1'b0, BMD, 8'h00);
		`CHK(q[7:0], 8'h80)
		for (int m = 3; m >= 0; m--) begin
			bus(1'b1, CTL, {3'(m), 5'h00});
			bus(1'b0, STA, 8'h00);
			`CHK(q[7:5], 3'(m))
		end
		bus(1'b0, BMD, 8'h00);
		`CHK(q[1:0], can_ctrl_pkg::BMODE_FIFO)
		fifo_ptr <= 4'($random(seed));
		bus(1'b0, CTL, 8'h00);
		`CHK(q[3:0], fifo_ptr)
		for (int i = 0; i < 4; i++) begin
			irq <= ein[i];
			bus(1'b0, STA, 8'h00);
			`CHK(q[4:0], eout[i])
		end
		irq <= '0;
		$display("test modes done");
		busy <= 1'b1;
		bus(1'b1, CTL, 8'h80);
		bus(1'b0, STA, 8'h00);
		`CHK(q[7:5], can_ctrl_pkg::MODE_NORMAL)
		busy <= 1'b0;
		repeat (4) @(posedge clock_i);
		bus(1'b0, STA, 8'h00);
		`CHK(q[7:5], can_ctrl_pkg::MODE_CONFIG)
		$display("test configuration entry done");
		bus(1'b1, can_ctrl_pkg::OFS_BIT_TIME, 8'h40);
		bus(1'b0, can_ctrl_pkg::OFS_BIT_TIME, 8'h00);
		`CHK(q[7:0], 8'h40)
		`CHK(bitc, 8'h40)
		bus(1'b1, can_ctrl_pkg::OFS_BIT_TIME, 8'h05);
		bus(1'b0, can_ctrl_pkg::OFS_BIT_TIME, 8'h00);
		`CHK(q[7:0], 8'(can_ctrl_pkg::MIN_BIT_CYCLES))
		`CHK(bitc, 8'(can_ctrl_pkg::MIN_BIT_CYCLES))
		`CHK(wakes, 0)
		bus(1'b1, can_ctrl_pkg::OFS_WAKE_CFG, 8'h01);
		bus(1'b1, CTL, 8'h20);
		busy <= 1'b1;
		repeat (16) @(posedge clock_i);
		`CHK(wakes != 0, 1'b1)
		$display("test bit time and wake-up done");
		tally_and_finish();
	end
endmodule
